// ==== include/qut_pkg.sv ====
// Package for the quadrature up/down timer: register map, field positions, bus carriers
package qut_pkg;

  // Register indices; byte address is four times the index (paddr[9:2] holds the low byte)
  localparam logic [31:0] QUT_IDX_RUN_CTRL  = 32'h0FFFF58C;
  localparam logic [31:0] QUT_IDX_CAPCOMP   = 32'hFFFFF58A;
  localparam logic [31:0] QUT_IDX_UNIT_MODE = 32'hFFFFF58B;
  localparam logic [31:0] QUT_IDX_PRESCALER = 32'hFFFFF58E;
  localparam logic [31:0] QUT_IDX_STATUS    = 32'hFFFFF58F;
  localparam logic [31:0] QUT_IDX_COUNTER   = 32'hFFFFF580;
  localparam logic [31:0] QUT_IDX_CMP0      = 32'hFFFFF581;
  localparam logic [31:0] QUT_IDX_CMP1      = 32'hFFFFF582;
  localparam logic [31:0] QUT_IDX_CC0       = 32'hFFFFF584;
  localparam logic [31:0] QUT_IDX_CC1       = 32'hFFFFF585;

  localparam int QUT_ADDR_W = 12;

  // Run control fields
  localparam int QUT_RUN_BIT      = 6;
  localparam int QUT_RELOAD_BIT   = 3;
  localparam int QUT_MCLR_BIT     = 2;
  localparam int QUT_CLRSRC_HI    = 1;
  localparam int QUT_CLRSRC_LO    = 0;
  localparam logic [7:0] QUT_RUN_CTRL_MASK = 8'h4F;

  // Unit mode fields
  localparam int QUT_OPMODE_BIT   = 7;
  localparam int QUT_OUTEN_BIT    = 3;
  localparam int QUT_ACTLVL_BIT   = 2;
  localparam int QUT_SUBMODE_BIT  = 0;
  localparam logic [7:0] QUT_UNIT_MODE_MASK = 8'h8D;

  // Capture/compare mode fields
  localparam int QUT_CC1_MODE_BIT = 1;
  localparam int QUT_CC0_MODE_BIT = 0;
  localparam logic [7:0] QUT_CAPCOMP_MASK = 8'h03;

  localparam logic [7:0] QUT_PRESC_MASK = 8'h07;

  // Clear source codes
  localparam logic [1:0] QUT_CLR_PIN   = 2'h0;
  localparam logic [1:0] QUT_CLR_MATCH = 2'h1;
  localparam logic [1:0] QUT_CLR_BOTH  = 2'h2;
  localparam logic [1:0] QUT_CLR_NONE  = 2'h3;

  // Reset values and counter maximum
  localparam logic [15:0] QUT_COUNT_RST = 16'h0000;
  localparam logic [7:0]  QUT_CTRL_RST  = 8'h00;
  localparam logic [7:0]  QUT_PRESC_RST = 8'h07;
  localparam logic [15:0] QUT_CNT_MAX   = 16'hFFFF;

  // Pin vector positions
  localparam int QUT_PIN_PHASE = 0;
  localparam int QUT_PIN_DIR   = 1;
  localparam int QUT_PIN_CLR   = 2;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [QUT_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
    logic [3:0]            pstrb;
  } qut_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } qut_apb_rsp_t;

  typedef struct packed {
    logic [2:0]   sync1;
    logic [2:0]   sync2;
    logic [2:0]   sync3;
    logic [2:0]   pin_lvl;
    logic [2:0]   pin_prev;
    logic [7:0]   pcnt;
    logic [15:0]  count;
    logic [15:0]  cmp0;
    logic [15:0]  cmp1;
    logic [15:0]  cc0;
    logic [15:0]  cc1;
    logic [7:0]   run_ctrl;
    logic [7:0]   unit_mode;
    logic [7:0]   capcomp;
    logic [7:0]   presc;
    logic         udf;
    logic         ovf;
    logic         down;
    logic         out_pin;
    qut_apb_rsp_t rsp;
  } qut_state_t;

endpackage : qut_pkg

// ==== logic/qut_timer.sv ====
// Quadrature up/down timer with general-purpose timer mode and APB register slave
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module qut_timer (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire qut_pkg::qut_apb_req_t apb_req,
  output var  qut_pkg::qut_apb_rsp_t apb_rsp,
  input  wire logic                 phase_input,
  input  wire logic                 direction_input,
  input  wire logic                 external_clear_input,
  output logic                      timer_output_pin
);
  import qut_pkg::*;

  qut_state_t st;
  qut_state_t next_st;

  logic        run;
  logic        enc_mode;
  logic        sub_b;
  logic        sub_a;
  logic [1:0]  clr_src;
  logic [2:0]  rise;
  logic [2:0]  chg;
  logic [2:0]  agree;
  logic [7:0]  div_mask;
  logic        tick;
  logic        step_up;
  logic        step_dn;
  logic        match_clr_up;
  logic        pin_clr_en;
  logic        acc;
  logic        done;
  logic        hit;
  logic [7:0]  idx;
  logic [31:0] rd_val;
  logic        lane0;
  logic        lane01;
  logic        ovf_set;
  logic        udf_set;

  always_comb begin
    next_st = st;

    run      = st.run_ctrl[QUT_RUN_BIT];
    enc_mode = st.unit_mode[QUT_OPMODE_BIT];
    sub_b    = enc_mode & st.unit_mode[QUT_SUBMODE_BIT];
    sub_a    = enc_mode & ~st.unit_mode[QUT_SUBMODE_BIT];
    clr_src  = st.run_ctrl[QUT_CLRSRC_HI:QUT_CLRSRC_LO];

    // Pins pass three flops; a level counts once the last two agree
    next_st.sync1 = {external_clear_input, direction_input, phase_input};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    agree         = ~(st.sync2 ^ st.sync3);
    next_st.pin_lvl  = (st.sync3 & agree) | (st.pin_lvl & ~agree);
    next_st.pin_prev = st.pin_lvl;
    rise = st.pin_lvl & ~st.pin_prev;
    chg  = st.pin_lvl ^ st.pin_prev;

    case (st.presc[2:0])
      3'h1:    div_mask = 8'h03;
      3'h2:    div_mask = 8'h07;
      3'h3:    div_mask = 8'h0F;
      3'h4:    div_mask = 8'h1F;
      3'h5:    div_mask = 8'h3F;
      3'h6:    div_mask = 8'h7F;
      3'h7:    div_mask = 8'hFF;
      default: div_mask = 8'h00;
    endcase
    next_st.pcnt = run ? 8'(st.pcnt + 8'h01) : 8'h00;
    tick = run & ~enc_mode & (div_mask != 8'h00) & ((st.pcnt & div_mask) == div_mask);

    // encoder stepping from phase and direction
    step_up = 1'b0;
    step_dn = 1'b0;
    if (!enc_mode) begin
      step_up = tick;
    end else if (run && st.presc[2]) begin
      case (st.presc[1:0])
        2'h0: begin
          step_dn = rise[QUT_PIN_PHASE] & st.pin_lvl[QUT_PIN_DIR];
          step_up = rise[QUT_PIN_PHASE] & ~st.pin_lvl[QUT_PIN_DIR];
        end
        2'h1: begin
          // Simultaneous edges on both pins cancel out
          step_up = rise[QUT_PIN_PHASE] & ~rise[QUT_PIN_DIR];
          step_dn = rise[QUT_PIN_DIR] & ~rise[QUT_PIN_PHASE];
        end
        2'h2: begin
          step_up = rise[QUT_PIN_PHASE] & st.pin_lvl[QUT_PIN_DIR];
          step_dn = rise[QUT_PIN_PHASE] & ~st.pin_lvl[QUT_PIN_DIR];
        end
        default: begin
          // Both edges of both pins; a double change is an illegal gray step and is dropped
          step_up = (chg[QUT_PIN_PHASE] ^ chg[QUT_PIN_DIR]) &
                    (st.pin_lvl[QUT_PIN_PHASE] ^ st.pin_prev[QUT_PIN_DIR]);
          step_dn = (chg[QUT_PIN_PHASE] ^ chg[QUT_PIN_DIR]) &
                    ~(st.pin_lvl[QUT_PIN_PHASE] ^ st.pin_prev[QUT_PIN_DIR]);
        end
      endcase
    end

    // APB slave: answer one cycle into the access phase, act on the completing edge
    acc    = apb_req.psel & apb_req.penable;
    done   = acc & st.rsp.pready;
    idx    = apb_req.paddr[9:2];
    lane0  = apb_req.pstrb[0];
    lane01 = &apb_req.pstrb[1:0];
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (apb_req.paddr[1:0] != 2'h0 || apb_req.paddr[QUT_ADDR_W-1:10] != '0) begin
      hit = 1'b0;
    end else begin
      case (idx)
        QUT_IDX_RUN_CTRL[7:0]:  rd_val = {24'h0, st.run_ctrl};
        QUT_IDX_CAPCOMP[7:0]:   rd_val = {24'h0, st.capcomp};
        QUT_IDX_UNIT_MODE[7:0]: rd_val = {24'h0, st.unit_mode};
        QUT_IDX_PRESCALER[7:0]: rd_val = {24'h0, st.presc};
        QUT_IDX_STATUS[7:0]:    rd_val = {29'h0, st.udf, st.ovf, st.down};
        // counter read is a direct snapshot, no read-side buffering
        QUT_IDX_COUNTER[7:0]:   rd_val = {16'h0, st.count};
        QUT_IDX_CMP0[7:0]:      rd_val = {16'h0, st.cmp0};
        QUT_IDX_CMP1[7:0]:      rd_val = {16'h0, st.cmp1};
        QUT_IDX_CC0[7:0]:       rd_val = {16'h0, st.cc0};
        QUT_IDX_CC1[7:0]:       rd_val = {16'h0, st.cc1};
        default:                hit = 1'b0;
      endcase
    end
    next_st.rsp.pready = acc & ~st.rsp.pready;
    if (acc && !st.rsp.pready) begin
      next_st.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_val;
      next_st.rsp.pslverr = ~hit;
    end

    if (done && apb_req.pwrite && hit) begin
      case (idx)
        // byte-wide control registers, reserved bits held at zero
        QUT_IDX_RUN_CTRL[7:0]: begin
          if (lane0) next_st.run_ctrl = apb_req.pwdata[7:0] & QUT_RUN_CTRL_MASK;
        end
        QUT_IDX_CAPCOMP[7:0]: begin
          if (lane0) next_st.capcomp = apb_req.pwdata[7:0] & QUT_CAPCOMP_MASK;
        end
        QUT_IDX_UNIT_MODE[7:0]: begin
          if (lane0) next_st.unit_mode = apb_req.pwdata[7:0] & QUT_UNIT_MODE_MASK;
        end
        QUT_IDX_PRESCALER[7:0]: begin
          if (lane0) next_st.presc = apb_req.pwdata[7:0] & QUT_PRESC_MASK;
        end
        // counter takes only a full 16-bit write, and only while the run bit is clear
        QUT_IDX_COUNTER[7:0]: begin
          if (lane01 && !run) next_st.count = apb_req.pwdata[15:0];
        end
        QUT_IDX_CMP0[7:0]: begin
          if (lane01) next_st.cmp0 = apb_req.pwdata[15:0];
        end
        QUT_IDX_CMP1[7:0]: begin
          if (lane01) next_st.cmp1 = apb_req.pwdata[15:0];
        end
        QUT_IDX_CC0[7:0]: begin
          if (lane01) next_st.cc0 = apb_req.pwdata[15:0];
        end
        QUT_IDX_CC1[7:0]: begin
          if (lane01) next_st.cc1 = apb_req.pwdata[15:0];
        end
        default: begin
        end
      endcase
    end

    // completed status read clears flags (a new wrap in the same cycle wins)
    if (done && !apb_req.pwrite && hit && idx == QUT_IDX_STATUS[7:0]) begin
      next_st.udf = 1'b0;
      next_st.ovf = 1'b0;
    end

    // sub-mode A match clear by source code
    // compare 0 match clear only on up steps
    // sub-mode B compare 0 clears upward
    match_clr_up = (~enc_mode & st.run_ctrl[QUT_MCLR_BIT]) |
                   (sub_a & (clr_src == QUT_CLR_MATCH || clr_src == QUT_CLR_BOTH)) |
                   sub_b;
    ovf_set = 1'b0;
    udf_set = 1'b0;
    if (step_up) begin
      if (match_clr_up && st.count == st.cmp0) begin
        next_st.count = QUT_COUNT_RST;
      end else begin
        next_st.count = 16'(st.count + 16'h0001);
        ovf_set = (st.count == QUT_CNT_MAX);
      end
    end else if (step_dn) begin
      // sub-mode B compare 1 clears downward
      if (sub_b && st.count == st.cmp1) begin
        next_st.count = QUT_COUNT_RST;
      end else if (st.count == QUT_COUNT_RST) begin
        udf_set = 1'b1;
        // reload from compare 0 on underflow in sub-mode A only
        if (sub_a && st.run_ctrl[QUT_RELOAD_BIT]) begin
          next_st.count = st.cmp0;
        end else begin
          next_st.count = QUT_CNT_MAX;
        end
      end else begin
        next_st.count = 16'(st.count - 16'h0001);
      end
    end

    // clear pin acts regardless of run bit
    // pin clear for source codes 00 and 10
    pin_clr_en = sub_a & (clr_src == QUT_CLR_PIN || clr_src == QUT_CLR_BOTH);
    if (pin_clr_en && rise[QUT_PIN_CLR]) begin
      next_st.count = QUT_COUNT_RST;
    end

    if (ovf_set) next_st.ovf = 1'b1;
    if (udf_set) next_st.udf = 1'b1;

    // Direction status: fixed up in timer mode
    if (!enc_mode) begin
      next_st.down = 1'b0;
    end else if (step_dn) begin
      next_st.down = 1'b1;
    end else if (step_up) begin
      next_st.down = 1'b0;
    end

    // capture only where the mode bit selects capture
    // direction pin captures only in timer mode
    if (!enc_mode && !st.capcomp[QUT_CC0_MODE_BIT] && rise[QUT_PIN_DIR]) begin
      next_st.cc0 = st.count;
    end
    // clear pin capture blocked while it clears in sub-mode A
    if (!st.capcomp[QUT_CC1_MODE_BIT] && !pin_clr_en && rise[QUT_PIN_CLR]) begin
      next_st.cc1 = st.count;
    end

    // output only in timer mode with output enabled
    // active level bit inverts the pin
    // PWM: active from zero until count reaches compare 1
    next_st.out_pin = st.unit_mode[QUT_ACTLVL_BIT] ^
                      (~enc_mode & st.unit_mode[QUT_OUTEN_BIT] & run & (st.count < st.cmp1));
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st           <= '0;
      st.count     <= QUT_COUNT_RST;
      st.run_ctrl  <= QUT_CTRL_RST;
      st.unit_mode <= QUT_CTRL_RST;
      st.capcomp   <= QUT_CTRL_RST;
      st.presc     <= QUT_PRESC_RST;
    end else begin
      st <= next_st;
    end
  end

  assign apb_rsp          = st.rsp;
  assign timer_output_pin = st.out_pin;

endmodule : qut_timer

`default_nettype wire

// ==== tb/qut_checker.sv ====
// Port checker for the quadrature timer
`timescale 1ns/1ns
`default_nettype none
module qut_checker (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire qut_pkg::qut_apb_req_t apb_req,
  input wire qut_pkg::qut_apb_rsp_t apb_rsp,
  input wire logic                  phase_input,
  input wire logic                  direction_input,
  input wire logic                  external_clear_input,
  input wire logic                  timer_output_pin
);
  import qut_pkg::*;
  wire logic [7:0] ix = apb_req.paddr[9:2];
  logic      [7:0] um;
  // Readable bits per register; zero marks an unmapped place
  function automatic logic [31:0] rmask(logic [7:0] a);
    case (a)
      QUT_IDX_RUN_CTRL[7:0]:  return {24'h0, QUT_RUN_CTRL_MASK};
      QUT_IDX_UNIT_MODE[7:0]: return {24'h0, QUT_UNIT_MODE_MASK};
      QUT_IDX_CAPCOMP[7:0]:   return {24'h0, QUT_CAPCOMP_MASK};
      QUT_IDX_PRESCALER[7:0]: return {24'h0, QUT_PRESC_MASK};
      QUT_IDX_STATUS[7:0]:    return 32'h00000007;
      QUT_IDX_COUNTER[7:0], QUT_IDX_CMP0[7:0], QUT_IDX_CMP1[7:0],
      QUT_IDX_CC0[7:0], QUT_IDX_CC1[7:0]: return 32'h0000FFFF;
      default: return 32'h0;
    endcase
  endfunction : rmask
  // Shadow of the mode register, seen from completed writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      um <= 8'h00;
    end else if (apb_rsp.pready && apb_req.pwrite && ix == QUT_IDX_UNIT_MODE[7:0] && apb_req.pstrb[0]) begin
      um <= apb_req.pwdata[7:0] & QUT_UNIT_MODE_MASK;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held past one cycle");
  ready_gated_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("pready outside an access");
  ready_timing_a: assert property (apb_req.psel && !apb_req.penable |=> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("pready not in second access cycle");
  reset_quiet_a: assert property ($fell(rst) |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pready
    && !apb_rsp.pslverr && !timer_output_pin) else $error("outputs not idle after reset");
  slverr_map_a: assert property (apb_rsp.pready |-> apb_rsp.pslverr == (rmask(ix) == 32'h0))
    else $error("pslverr does not match address map");
  rdata_hold_a: assert property (!apb_rsp.pready |-> $stable(apb_rsp.prdata))
    else $error("prdata moved between answers");
  read_width_a: assert property (apb_rsp.pready && !apb_req.pwrite && !apb_rsp.pslverr
    |-> (apb_rsp.prdata & ~rmask(ix)) == 32'h0) else $error("reserved read bits not zero");
  out_idle_a: assert property ((!um[3] || um[7]) && um == $past(um) && um == $past(um, 2)
    |-> timer_output_pin == um[2]) else $error("output not at inactive level");
endmodule : qut_checker
bind qut_timer qut_checker i_qut_checker (
  .sys_clk(sys_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .phase_input(phase_input), .direction_input(direction_input),
  .external_clear_input(external_clear_input), .timer_output_pin(timer_output_pin));
`default_nettype wire

// ==== tb/qut_encoder_model.sv ====
// Encoder and clear pin model for the timer's input pins
`timescale 1ns/1ns
`default_nettype none
module qut_encoder_model (
  input  wire logic sys_clk,
  output var  logic phase_input,
  output var  logic direction_input,
  output var  logic external_clear_input
);
  initial begin
    phase_input = 1'b0;
    direction_input = 1'b0;
    external_clear_input = 1'b0;
  end
  // Pulses stay w cycles per level; w of 2 or more keeps the synchroniser honest
  task automatic pulse(input int pin, input int n, input int w);
    for (int i = 0; i < 2 * n; i++) begin
      repeat (w) @(posedge sys_clk);
      if (pin == 0) phase_input <= ~phase_input;
      else if (pin == 1) direction_input <= ~direction_input;
      else external_clear_input <= ~external_clear_input;
    end
    repeat (w + 8) @(posedge sys_clk);
  endtask : pulse
  task automatic set_dir(input logic d);
    @(posedge sys_clk);
    direction_input <= d;
    repeat (8) @(posedge sys_clk);
  endtask : set_dir
  // Phase leads direction: n full gray cycles, four single-pin steps each
  task automatic quad(input int n, input int w);
    for (int i = 0; i < 2 * n; i++) begin
      repeat (w) @(posedge sys_clk);
      phase_input <= ~phase_input;
      repeat (w) @(posedge sys_clk);
      direction_input <= ~direction_input;
    end
    repeat (w + 8) @(posedge sys_clk);
  endtask : quad
endmodule : qut_encoder_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the quadrature timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  import qut_pkg::*;
  localparam logic [7:0] CNT = QUT_IDX_COUNTER[7:0];
  localparam logic [7:0] C0 = QUT_IDX_CMP0[7:0];
  localparam logic [7:0] C1 = QUT_IDX_CMP1[7:0];
  localparam logic [7:0] CCM = QUT_IDX_CAPCOMP[7:0];
  localparam logic [7:0] UM = QUT_IDX_UNIT_MODE[7:0];
  localparam logic [7:0] RC = QUT_IDX_RUN_CTRL[7:0];
  localparam logic [7:0] PS = QUT_IDX_PRESCALER[7:0];
  localparam logic [7:0] ST = QUT_IDX_STATUS[7:0];
  logic         sys_clk;
  logic         rst;
  qut_apb_req_t req;
  qut_apb_rsp_t rsp;
  logic         ph, dr, cl, pin, err;
  logic [31:0]  rdv;
  logic [15:0]  r, r16;
  logic [7:0]   v;
  int           fail_count, checked, n, w;
  logic [7:0]   ra [6] = '{CNT, RC, UM, CCM, ST, PS};
  // Mode, control, start, direction, expected count
  // Ordered so that no start value repeats the count left by the entry before it
  logic [51:0]  st [7] = '{52'h8041_0003_0_0000, 52'h8041_0003_1_0002, 52'h804B_0000_1_0003,
    52'h814B_0000_1_FFFF, 52'h8143_0005_1_0000, 52'h8143_0003_0_0000, 52'h8043_FFFF_0_0000};
  qut_timer i_qut_timer (.sys_clk(sys_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .phase_input(ph),
    .direction_input(dr), .external_clear_input(cl), .timer_output_pin(pin));
  qut_encoder_model i_qut_encoder_model (.sys_clk(sys_clk), .phase_input(ph), .direction_input(dr),
    .external_clear_input(cl));
  function automatic logic near(logic [15:0] g, int e);
    return ({1'b0, g} <= 17'(e + 1)) && ({1'b0, g} + 17'h00001 >= 17'(e));
  endfunction : near
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic apb(input logic wr, input logic [7:0] ix, input logic [15:0] d);
    int k = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, ix, 2'b00}, pwdata: {16'h0, d}, pstrb: 4'hF};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    rdv = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge sys_clk);
    if (k >= 20) begin
      fail_count++;
      complete_run();
    end
  endtask : apb
  task automatic wr(input logic [7:0] ix, input logic [15:0] d);
    apb(1'b1, ix, d);
  endtask : wr
  task automatic rd(input logic [7:0] ix);
    apb(1'b0, ix, 16'h0);
  endtask : rd
  task automatic rdc();
    rd(CNT);
    r16 = rdv[15:0];
    rd(PS);
  endtask : rdc
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'b1;
    req = '0;
    fail_count = 0;
    checked = 0;
    void'($urandom(90552));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (ra[j]) begin
      rd(ra[j]);
      `CHK(rdv, (ra[j] == PS) ? 32'h00000007 : 32'h00000000)
    end
    rd(8'h83);
    `CHK(err, 1'b1)
    r = 16'($urandom);
    // Sub-mode B only in encoder mode
    v = {r[7], 3'h0, r[3:2], 1'b0, r[7] & r[0]};
    wr(CCM, {14'h0, r[1:0]}); rd(CCM);
    `CHK(rdv, {30'h0, r[1:0]})
    wr(UM, {8'h0, v}); rd(UM);
    `CHK(rdv, {24'h0, v})
    wr(UM, 16'h0); wr(PS, 16'h0); wr(CNT, r); rdc();
    `CHK(r16, r)
    wr(RC, 16'h40); wr(CNT, ~r); wr(RC, 16'h40); rdc();
    `CHK(r16, r)
    $display("registers done");
    for (int c = 1; c < 8; c++) begin
      wr(RC, 16'h0); wr(CNT, 16'h0); wr(PS, 16'(c)); wr(RC, 16'h40);
      repeat (1024) @(posedge sys_clk);
      wr(RC, 16'h0); rdc();
      `CHK(near(r16, 1027 >> (c + 1)), 1'b1)
    end
    wr(PS, 16'h1); wr(CNT, 16'hFFFC); wr(C0, 16'h5); wr(RC, 16'h40);
    repeat (100) @(posedge sys_clk);
    wr(RC, 16'h0); rd(ST);
    `CHK(rdv, 32'h00000002)
    rd(ST);
    `CHK(rdv, 32'h00000000)
    rdc();
    `CHK(near(r16, 103 / 4 - 4), 1'b1)
    wr(CNT, 16'h0); wr(RC, 16'h44);
    repeat (100) @(posedge sys_clk);
    wr(RC, 16'h0); rdc();
    `CHK(r16 <= 16'h0005, 1'b1)
    wr(CNT, 16'h0); wr(C1, 16'h8000); wr(PS, 16'h7);
    for (int a = 0; a < 2; a++) begin
      wr(UM, 16'(8 + 4 * a)); wr(RC, 16'h40);
      repeat (2) @(posedge sys_clk);
      `CHK(pin, 1'(a == 0))
      wr(RC, 16'h0);
    end
    $display("timer mode done");
    wr(UM, 16'h80);
    for (int k = 0; k < 4; k++) begin
      n = 1 + $urandom % 6;
      w = 4 + $urandom % 4;
      wr(RC, 16'h0); wr(PS, 16'(k == 2 ? 6 : k == 3 ? 5 : 4)); wr(CNT, 16'h10);
      i_qut_encoder_model.set_dir(k == 1 || k == 2);
      wr(RC, 16'h43);
      i_qut_encoder_model.pulse(k == 3, n, w);
      rdc();
      `CHK(r16, (k == 0 || k == 2) ? 16'(16 + n) : 16'(16 - n))
    end
    wr(RC, 16'h0); wr(PS, 16'h7); wr(CNT, 16'h10); wr(RC, 16'h43);
    i_qut_encoder_model.quad(n, 5);
    rdc();
    `CHK(r16, 16'(16 + 4 * n))
    wr(RC, 16'h0); wr(PS, 16'h4);
    for (int k = 0; k < 4; k++) begin
      // Counter never rewritten with its own value
      wr(RC, 16'(k)); wr(CNT, 16'(16'h0055 + k));
      i_qut_encoder_model.pulse(2, 1, 4);
      rdc();
      `CHK(r16, (k % 2 == 0) ? 16'h0000 : 16'(16'h0055 + k))
    end
    wr(C0, 16'h3); wr(C1, 16'h5);
    foreach (st[j]) begin
      wr(RC, 16'h0); wr(UM, 16'(st[j][51:44])); wr(CNT, st[j][35:20]);
      i_qut_encoder_model.set_dir(st[j][16]);
      wr(RC, 16'(st[j][43:36]));
      i_qut_encoder_model.pulse(0, 1, 5);
      rdc();
      `CHK(r16, st[j][15:0])
    end
    $display("encoder mode done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
